// [pin_mux_pkg.sv]
package pin_mux_pkg;

	// Strap codes for the memory pin partition
	localparam logic [3:0] STRAP_NAND = 4'hD;
	localparam logic [3:0] STRAP_C = 4'hC;
	localparam logic [3:0] STRAP_A = 4'hA;
	localparam logic [3:0] STRAP_SRAM8 = 4'h8;
	localparam logic [3:0] STRAP_SRAM16 = 4'h2;
	localparam logic [3:0] STRAP_ZERO = 4'h0;
	localparam logic [3:0] STRAP_DEFAULT = STRAP_NAND;

	// Widths of the shared pin groups
	localparam int ADDR_W = 14;
	localparam int DATA_HI_W = 8;
	localparam int VIN_W = 16;
	localparam int VOUT_W = 16;
	localparam int GIO_W = 16;
	localparam int SER_W = 8;

	// Memory mux register layout
	localparam int MEM_SEL_W = 32;
	localparam int F_ADDR_EN_LO = 0;
	localparam int F_TOP_A14 = 14;
	localparam int F_TOP_BA0 = 15;
	localparam int F_BA1_EN = 16;
	localparam int F_DATA_HI = 17;
	localparam int F_HALF_RATE_N = 18;

	// Three-way function encoding for mixed groups
	localparam logic [1:0] FN_PRIMARY = 2'h0;
	localparam logic [1:0] FN_SECONDARY = 2'h1;
	localparam logic [1:0] FN_TERTIARY = 2'h2;
	localparam logic [1:0] FN_GPIO2 = 2'h3;

endpackage : pin_mux_pkg

// [pin_group_sel.sv]
`timescale 1ns/10ps
// One pin group of W lanes choosing between up to three function sources
module pin_group_sel #(
	parameter int W = 8
) (
	input wire logic [1:0] sel,
	input wire logic [W-1:0] fn0_out,
	input wire logic [W-1:0] fn0_oe,
	input wire logic [W-1:0] fn1_out,
	input wire logic [W-1:0] fn1_oe,
	input wire logic [W-1:0] fn2_out,
	input wire logic [W-1:0] fn2_oe,
	output logic [W-1:0] pin_out,
	output logic [W-1:0] pin_oe
);
	import pin_mux_pkg::*;

	// Unused code falls back to the third function
	always_comb begin
		case (sel)
			FN_PRIMARY: begin
				pin_out = fn0_out;
				pin_oe = fn0_oe;
			end
			FN_SECONDARY: begin
				pin_out = fn1_out;
				pin_oe = fn1_oe;
			end
			default: begin
				pin_out = fn2_out;
				pin_oe = fn2_oe;
			end
		endcase
	end

endmodule : pin_group_sel

// [async_mem_gpio_pin_mux.sv]
`timescale 1ns/10ps
module async_mem_gpio_pin_mux (
	input wire logic clock,
	input wire logic rstn,
	// Strap level on the shared address pins
	input wire logic [3:0] mem_pin_config_strap,
	input wire logic strap_driven,
	// Software mux writes
	input wire logic mem_if_sel_we,
	input wire logic [pin_mux_pkg::MEM_SEL_W-1:0] mem_if_sel_wdata,
	input wire logic video_in_sel_we,
	input wire logic [1:0] video_in_sel_wdata,
	input wire logic video_out_sel_we,
	input wire logic [1:0] video_out_sel_wdata,
	input wire logic gio_sel_we,
	input wire logic [pin_mux_pkg::GIO_W-1:0] gio_sel_wdata,
	input wire logic serial_card_sel_we,
	input wire logic [1:0] serial_card_sel_wdata,
	// Memory interface side
	input wire logic [pin_mux_pkg::ADDR_W-1:0] mem_addr,
	input wire logic [1:0] mem_bank_addr,
	input wire logic mem_addr14,
	input wire logic [pin_mux_pkg::DATA_HI_W-1:0] mem_data_hi_out,
	input wire logic mem_data_hi_oe,
	output logic [pin_mux_pkg::DATA_HI_W-1:0] mem_data_hi_in,
	// GPIO side for the memory pins (gpio 46..67)
	input wire logic [21:0] mem_gpio_out,
	input wire logic [21:0] mem_gpio_oe,
	output logic [21:0] mem_gpio_in,
	// Memory pins
	output logic [pin_mux_pkg::ADDR_W-1:0] ext_mem_addr_pin_out,
	output logic [pin_mux_pkg::ADDR_W-1:0] ext_mem_addr_pin_oe,
	input wire logic [pin_mux_pkg::ADDR_W-1:0] ext_mem_addr_pin_in,
	output logic [1:0] ext_mem_bank_addr_pin_out,
	output logic [1:0] ext_mem_bank_addr_pin_oe,
	input wire logic [1:0] ext_mem_bank_addr_pin_in,
	output logic [pin_mux_pkg::DATA_HI_W-1:0] ext_mem_data_pin_out,
	output logic [pin_mux_pkg::DATA_HI_W-1:0] ext_mem_data_pin_oe,
	input wire logic [pin_mux_pkg::DATA_HI_W-1:0] ext_mem_data_pin_in,
	// Video in group: front end, serial port 2, GPIO
	input wire logic [pin_mux_pkg::VIN_W-1:0] vin_spi_out,
	input wire logic [pin_mux_pkg::VIN_W-1:0] vin_spi_oe,
	input wire logic [pin_mux_pkg::VIN_W-1:0] vin_gpio_out,
	input wire logic [pin_mux_pkg::VIN_W-1:0] vin_gpio_oe,
	output logic [pin_mux_pkg::VIN_W-1:0] vin_pin_out,
	output logic [pin_mux_pkg::VIN_W-1:0] vin_pin_oe,
	// Video out group: back end, PWM and real-time out, GPIO
	input wire logic [pin_mux_pkg::VOUT_W-1:0] vout_out,
	input wire logic [pin_mux_pkg::VOUT_W-1:0] vout_pwm_out,
	input wire logic [pin_mux_pkg::VOUT_W-1:0] vout_gpio_out,
	input wire logic [pin_mux_pkg::VOUT_W-1:0] vout_gpio_oe,
	output logic [pin_mux_pkg::VOUT_W-1:0] vout_pin_out,
	output logic [pin_mux_pkg::VOUT_W-1:0] vout_pin_oe,
	// General pins: peripheral or GPIO per bit
	input wire logic [pin_mux_pkg::GIO_W-1:0] gio_periph_out,
	input wire logic [pin_mux_pkg::GIO_W-1:0] gio_periph_oe,
	input wire logic [pin_mux_pkg::GIO_W-1:0] gio_gpio_out,
	input wire logic [pin_mux_pkg::GIO_W-1:0] gio_gpio_oe,
	output logic [pin_mux_pkg::GIO_W-1:0] gio_pin_out,
	output logic [pin_mux_pkg::GIO_W-1:0] gio_pin_oe,
	// Serial and card group: card port, GPIO, UART2
	input wire logic [pin_mux_pkg::SER_W-1:0] ser_card_out,
	input wire logic [pin_mux_pkg::SER_W-1:0] ser_card_oe,
	input wire logic [pin_mux_pkg::SER_W-1:0] ser_gpio_out,
	input wire logic [pin_mux_pkg::SER_W-1:0] ser_gpio_oe,
	input wire logic [pin_mux_pkg::SER_W-1:0] ser_uart_out,
	input wire logic [pin_mux_pkg::SER_W-1:0] ser_uart_oe,
	output logic [pin_mux_pkg::SER_W-1:0] ser_pin_out,
	output logic [pin_mux_pkg::SER_W-1:0] ser_pin_oe,
	// Status
	output logic [3:0] mem_pin_strap_code,
	output logic [pin_mux_pkg::MEM_SEL_W-1:0] mem_if_pin_select_reg,
	output logic mem_half_rate,
	output logic [1:0] video_in_pin_select_reg,
	output logic [1:0] video_out_pin_select_reg,
	output logic [pin_mux_pkg::GIO_W-1:0] gio_pin_select_reg,
	output logic [1:0] serial_card_pin_select_reg
);
	import pin_mux_pkg::*;

	logic in_reset_r;
	logic in_reset_nxt;
	logic [3:0] strap_r;
	logic [3:0] strap_nxt;
	logic [MEM_SEL_W-1:0] mem_sel_r;
	logic [MEM_SEL_W-1:0] mem_sel_nxt;
	logic [1:0] vin_sel_r;
	logic [1:0] vin_sel_nxt;
	logic [1:0] vout_sel_r;
	logic [1:0] vout_sel_nxt;
	logic [GIO_W-1:0] gio_sel_r;
	logic [GIO_W-1:0] gio_sel_nxt;
	logic [1:0] ser_sel_r;
	logic [1:0] ser_sel_nxt;
	logic [3:0] strap_eff;
	logic [MEM_SEL_W-1:0] strap_sel;

	// Effective strap: undriven pins pull to NAND
	always_comb begin
		strap_eff = strap_driven ? mem_pin_config_strap : STRAP_DEFAULT;
	end

	// Strap code to partition; one address-enable bit per address pin
	always_comb begin
		strap_sel = '0;
		strap_sel[F_ADDR_EN_LO +: ADDR_W] = {ADDR_W{1'b1}};
		strap_sel[F_BA1_EN] = 1'b1;
		strap_sel[F_TOP_A14] = 1'b0;
		strap_sel[F_TOP_BA0] = 1'b0;
		strap_sel[F_DATA_HI] = 1'b0;
		case (strap_eff)
			STRAP_C: begin
			end
			STRAP_A: strap_sel[F_TOP_A14] = 1'b1;
			STRAP_SRAM8: strap_sel[F_TOP_BA0] = 1'b1;
			STRAP_SRAM16: begin
				strap_sel[F_TOP_A14] = 1'b1;
				strap_sel[F_DATA_HI] = 1'b1;
			end
			STRAP_ZERO: begin
				strap_sel[F_TOP_BA0] = 1'b1;
				strap_sel[F_DATA_HI] = 1'b1;
			end
			default: begin
				// NAND or any unlisted code: only the latch-enable pins stay address
				strap_sel[F_ADDR_EN_LO +: ADDR_W] = '0;
				strap_sel[F_BA1_EN] = 1'b0;
			end
		endcase
	end

	// Register next values: strap at release, software writes after
	always_comb begin
		in_reset_nxt = 1'b0;
		strap_nxt = strap_r;
		mem_sel_nxt = mem_sel_r;
		vin_sel_nxt = vin_sel_r;
		vout_sel_nxt = vout_sel_r;
		gio_sel_nxt = gio_sel_r;
		ser_sel_nxt = ser_sel_r;
		if (in_reset_r) begin
			// First edge after release catches the strap, held thereafter
			strap_nxt = strap_eff;
			mem_sel_nxt = strap_sel;
		end else begin
			// Contents are not validated; board and software own this
			if (mem_if_sel_we) mem_sel_nxt = mem_if_sel_wdata;
			if (video_in_sel_we) vin_sel_nxt = video_in_sel_wdata;
			if (video_out_sel_we) vout_sel_nxt = video_out_sel_wdata;
			if (gio_sel_we) gio_sel_nxt = gio_sel_wdata;
			if (serial_card_sel_we) ser_sel_nxt = serial_card_sel_wdata;
		end
	end

	// Sync reset; strap sampled on the first clock after release
	always_ff @(posedge clock) begin
		if (!rstn) begin
			in_reset_r <= 1'b1;
			strap_r <= STRAP_DEFAULT;
			mem_sel_r <= '0;
			vin_sel_r <= FN_PRIMARY;
			vout_sel_r <= FN_PRIMARY;
			gio_sel_r <= '0;
			ser_sel_r <= FN_PRIMARY;
		end else begin
			in_reset_r <= in_reset_nxt;
			strap_r <= strap_nxt;
			mem_sel_r <= mem_sel_nxt;
			vin_sel_r <= vin_sel_nxt;
			vout_sel_r <= vout_sel_nxt;
			gio_sel_r <= gio_sel_nxt;
			ser_sel_r <= ser_sel_nxt;
		end
	end

	// Memory pins; while strapping, the address pins are released (inputs)
	always_comb begin
		for (int i = 0; i < ADDR_W; i++) begin
			if (i == 1 || i == 2) begin
				ext_mem_addr_pin_out[i] = mem_addr[i];
				ext_mem_addr_pin_oe[i] = ~in_reset_r;
			end else if (mem_sel_r[F_ADDR_EN_LO + i]) begin
				ext_mem_addr_pin_out[i] = mem_addr[i];
				ext_mem_addr_pin_oe[i] = ~in_reset_r;
			end else begin
				// A0 maps to GPIO56, A3..A13 to GPIO57..67
				ext_mem_addr_pin_out[i] = mem_gpio_out[(i == 0) ? 10 : 8 + i];
				ext_mem_addr_pin_oe[i] = mem_gpio_oe[(i == 0) ? 10 : 8 + i] & ~in_reset_r;
			end
		end
		// Bank pin 1 or GPIO55
		if (mem_sel_r[F_BA1_EN]) begin
			ext_mem_bank_addr_pin_out[1] = mem_bank_addr[1];
			ext_mem_bank_addr_pin_oe[1] = 1'b1;
		end else begin
			ext_mem_bank_addr_pin_out[1] = mem_gpio_out[9];
			ext_mem_bank_addr_pin_oe[1] = mem_gpio_oe[9];
		end
		// Top pin: A14, bank 0, or GPIO54
		if (mem_sel_r[F_TOP_A14]) begin
			ext_mem_bank_addr_pin_out[0] = mem_addr14;
			ext_mem_bank_addr_pin_oe[0] = 1'b1;
		end else if (mem_sel_r[F_TOP_BA0]) begin
			ext_mem_bank_addr_pin_out[0] = mem_bank_addr[0];
			ext_mem_bank_addr_pin_oe[0] = 1'b1;
		end else begin
			ext_mem_bank_addr_pin_out[0] = mem_gpio_out[8];
			ext_mem_bank_addr_pin_oe[0] = mem_gpio_oe[8];
		end
		// Upper data byte or GPIO46..53
		if (mem_sel_r[F_DATA_HI]) begin
			ext_mem_data_pin_out = mem_data_hi_out;
			ext_mem_data_pin_oe = {DATA_HI_W{mem_data_hi_oe}};
		end else begin
			ext_mem_data_pin_out = mem_gpio_out[7:0];
			ext_mem_data_pin_oe = mem_gpio_oe[7:0];
		end
	end

	// Input paths back to GPIO and memory
	always_comb begin
		mem_gpio_in = {ext_mem_addr_pin_in[13:3], ext_mem_addr_pin_in[0],
			ext_mem_bank_addr_pin_in[1], ext_mem_bank_addr_pin_in[0], ext_mem_data_pin_in};
		mem_data_hi_in = ext_mem_data_pin_in;
	end

	// Three-way groups share one selector module
	pin_group_sel #(.W(VIN_W)) vin_mux (
		.sel(vin_sel_r),
		.fn0_out('0),
		.fn0_oe('0),
		.fn1_out(vin_spi_out),
		.fn1_oe(vin_spi_oe),
		.fn2_out(vin_gpio_out),
		.fn2_oe(vin_gpio_oe),
		.pin_out(vin_pin_out),
		.pin_oe(vin_pin_oe)
	);
	pin_group_sel #(.W(VOUT_W)) vout_mux (
		.sel(vout_sel_r),
		.fn0_out(vout_out),
		.fn0_oe({VOUT_W{1'b1}}),
		.fn1_out(vout_pwm_out),
		.fn1_oe({VOUT_W{1'b1}}),
		.fn2_out(vout_gpio_out),
		.fn2_oe(vout_gpio_oe),
		.pin_out(vout_pin_out),
		.pin_oe(vout_pin_oe)
	);
	pin_group_sel #(.W(SER_W)) ser_mux (
		.sel(ser_sel_r),
		.fn0_out(ser_card_out),
		.fn0_oe(ser_card_oe),
		.fn1_out(ser_gpio_out),
		.fn1_oe(ser_gpio_oe),
		.fn2_out(ser_uart_out),
		.fn2_oe(ser_uart_oe),
		.pin_out(ser_pin_out),
		.pin_oe(ser_pin_oe)
	);

	// Two-way general pins: select bit 1 means GPIO
	always_comb begin
		gio_pin_out = (gio_sel_r & gio_gpio_out) | (~gio_sel_r & gio_periph_out);
		gio_pin_oe = (gio_sel_r & gio_gpio_oe) | (~gio_sel_r & gio_periph_oe);
	end

	// Status readback
	always_comb begin
		mem_pin_strap_code = strap_r;
		mem_if_pin_select_reg = mem_sel_r;
		mem_half_rate = ~mem_sel_r[F_HALF_RATE_N];
		video_in_pin_select_reg = vin_sel_r;
		video_out_pin_select_reg = vout_sel_r;
		gio_pin_select_reg = gio_sel_r;
		serial_card_pin_select_reg = ser_sel_r;
	end

endmodule : async_mem_gpio_pin_mux

// [pin_mux_chk.sv]
`timescale 1ns/10ps
module pin_mux_chk (
	input wire logic clock,
	input wire logic rstn,
	input wire logic mem_if_sel_we,
	input wire logic [pin_mux_pkg::MEM_SEL_W-1:0] mem_if_sel_wdata,
	input wire logic video_in_sel_we,
	input wire logic [1:0] video_in_sel_wdata,
	input wire logic [1:0] mem_bank_addr,
	input wire logic mem_addr14,
	input wire logic [pin_mux_pkg::DATA_HI_W-1:0] mem_data_hi_out,
	input wire logic [pin_mux_pkg::ADDR_W-1:0] ext_mem_addr_pin_oe,
	input wire logic [1:0] ext_mem_bank_addr_pin_out,
	input wire logic [pin_mux_pkg::DATA_HI_W-1:0] ext_mem_data_pin_out,
	input wire logic [3:0] mem_pin_strap_code,
	input wire logic [pin_mux_pkg::MEM_SEL_W-1:0] mem_if_pin_select_reg,
	input wire logic mem_half_rate,
	input wire logic [1:0] video_in_pin_select_reg
);
	import pin_mux_pkg::*;
	// One clock domain; nothing is judged while reset is low
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rstn);
	// The capture edge is skipped through the past of reset
	latch_pins_a: assert property ($past(rstn) |-> ext_mem_addr_pin_oe[2:1] == 2'b11)
		else $error("latch pins not driven");
	mem_sel_a: assert property ($past(rstn) && mem_if_sel_we |=>
		mem_if_pin_select_reg == $past(mem_if_sel_wdata)) else $error("mem select lost");
	stands_a: assert property ($past(rstn) && !mem_if_sel_we |=>
		$stable(mem_if_pin_select_reg)) else $error("mem select moved");
	half_rate_a: assert property ($past(rstn) |->
		mem_half_rate == !mem_if_pin_select_reg[F_HALF_RATE_N]) else $error("rate flag");
	strap_hold_a: assert property ($past(rstn) && $past(rstn, 2) |->
		$stable(mem_pin_strap_code)) else $error("strap code moved");
	vin_sel_a: assert property ($past(rstn) && video_in_sel_we |=>
		video_in_pin_select_reg == $past(video_in_sel_wdata)) else $error("video in select");
	ba1_addr_a: assert property (mem_if_pin_select_reg[F_BA1_EN] |->
		ext_mem_bank_addr_pin_out[1] == mem_bank_addr[1]) else $error("bank pin 1");
	top_a14_a: assert property (mem_if_pin_select_reg[F_TOP_A14] |->
		ext_mem_bank_addr_pin_out[0] == mem_addr14) else $error("top pin");
	data_hi_a: assert property (mem_if_pin_select_reg[F_DATA_HI] |->
		ext_mem_data_pin_out == mem_data_hi_out) else $error("upper data");
endmodule : pin_mux_chk

bind async_mem_gpio_pin_mux pin_mux_chk u_chk (.clock, .rstn, .mem_if_sel_we,
	.mem_if_sel_wdata, .video_in_sel_we, .video_in_sel_wdata, .mem_bank_addr, .mem_addr14,
	.mem_data_hi_out, .ext_mem_addr_pin_oe, .ext_mem_bank_addr_pin_out, .ext_mem_data_pin_out,
	.mem_pin_strap_code, .mem_if_pin_select_reg, .mem_half_rate, .video_in_pin_select_reg);

// [board_pins.sv]
`timescale 1ns/10ps
module board_pins (
	input wire logic clock,
	input wire logic [23:0] drv_out,
	input wire logic [23:0] drv_oe,
	output logic [23:0] pin_in
);
	logic [23:0] pat_r = 24'hA5C3F0;
	// Released lines toggle each cycle so a stale level never passes
	always @(posedge clock) pat_r <= ~pat_r;
	assign pin_in = (drv_out & drv_oe) | (pat_r & ~drv_oe);
endmodule : board_pins

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
	import pin_mux_pkg::*;
	logic clock = 0, rstn = 0, strap_driven = 0, mem_addr14, mem_data_hi_oe, mem_half_rate;
	logic [1:0] mem_bank_addr, ext_mem_bank_addr_pin_out, ext_mem_bank_addr_pin_oe;
	logic [1:0] video_in_pin_select_reg, video_out_pin_select_reg, serial_card_pin_select_reg;
	logic [3:0] mem_pin_config_strap = 0, mem_pin_strap_code, code;
	logic [4:0] we = 0;
	logic [7:0] mem_data_hi_out, mem_data_hi_in, ext_mem_data_pin_out, ext_mem_data_pin_oe;
	logic [7:0] ser_card_out, ser_card_oe, ser_gpio_out, ser_gpio_oe, ser_uart_out, ser_uart_oe;
	logic [7:0] ser_pin_out, ser_pin_oe;
	logic [13:0] mem_addr, ext_mem_addr_pin_out, ext_mem_addr_pin_oe, en;
	logic [15:0] vin_spi_out, vin_spi_oe, vin_gpio_out, vin_gpio_oe, vin_pin_out, vin_pin_oe;
	logic [15:0] vout_out, vout_pwm_out, vout_gpio_out, vout_gpio_oe, vout_pin_out, vout_pin_oe;
	logic [15:0] gio_periph_out, gio_periph_oe, gio_gpio_out, gio_gpio_oe, gio_pin_out, gio_pin_oe;
	logic [15:0] gio_pin_select_reg;
	logic [21:0] mem_gpio_out, mem_gpio_oe, mem_gpio_in;
	logic [23:0] bin, eo, ee;
	logic [31:0] wd = 0, mem_if_pin_select_reg, d, c32, es [5];
	logic [319:0] pool;
	int seed = 59, err_total = 0, n_checks = 0;

	async_mem_gpio_pin_mux u_async_mem_gpio_pin_mux (.*, .mem_if_sel_we(we[0]),
		.video_in_sel_we(we[1]), .video_out_sel_we(we[2]), .gio_sel_we(we[3]),
		.serial_card_sel_we(we[4]), .mem_if_sel_wdata(wd), .video_in_sel_wdata(wd[1:0]),
		.video_out_sel_wdata(wd[1:0]), .gio_sel_wdata(wd[15:0]),
		.serial_card_sel_wdata(wd[1:0]), .ext_mem_addr_pin_in(bin[23:10]),
		.ext_mem_bank_addr_pin_in(bin[9:8]), .ext_mem_data_pin_in(bin[7:0]));
	board_pins u_board_pins (.clock, .drv_out({ext_mem_addr_pin_out, ext_mem_bank_addr_pin_out,
		ext_mem_data_pin_out}), .drv_oe({ext_mem_addr_pin_oe, ext_mem_bank_addr_pin_oe,
		ext_mem_data_pin_oe}), .pin_in(bin));

	// 25 MHz clock; peripheral sources change on every rising edge
	always #20 clock = ~clock;
	always @(posedge clock) rnd();

	task automatic rnd;
		for (int i = 0; i < 10; i++) begin
			pool[i*32+:32] = $random(seed);
		end
		{mem_addr, mem_bank_addr, mem_addr14, mem_data_hi_out, mem_data_hi_oe, mem_gpio_out,
			mem_gpio_oe, vin_spi_out, vin_spi_oe, vin_gpio_out, vin_gpio_oe, vout_out,
			vout_pwm_out, vout_gpio_out, vout_gpio_oe, gio_periph_out, gio_periph_oe,
			gio_gpio_out, gio_gpio_oe, ser_card_out, ser_card_oe, ser_gpio_out, ser_gpio_oe,
			ser_uart_out, ser_uart_oe} <= pool[309:0];
	endtask : rnd

	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : cmp

	// Memory select layout that each strap code should load
	function automatic logic [31:0] sf(input logic [3:0] c);
		case (c)
			STRAP_C: return 32'h0001_3FFF;
			STRAP_A: return 32'h0001_7FFF;
			STRAP_SRAM8: return 32'h0001_BFFF;
			STRAP_SRAM16: return 32'h0003_7FFF;
			STRAP_ZERO: return 32'h0003_BFFF;
			// Latch pins 2:1 are forced on in the logic, so they stay clear here
			default: return 32'h0000_0000;
		endcase
	endfunction : sf

	// Every pin group against the selections the bench believes in
	task automatic pins;
		logic [31:0] m;
		m = es[0];
		en = m[13:0] | 14'h0006;
		eo[23:10] = (mem_addr & en) | ({mem_gpio_out[21:11], 2'b00, mem_gpio_out[10]} & ~en);
		ee[23:10] = en | {mem_gpio_oe[21:11], 2'b00, mem_gpio_oe[10]};
		eo[9] = m[16] ? mem_bank_addr[1] : mem_gpio_out[9];
		ee[9] = m[16] | mem_gpio_oe[9];
		eo[8] = m[14] ? mem_addr14 : m[15] ? mem_bank_addr[0] : mem_gpio_out[8];
		ee[8] = m[14] | m[15] | mem_gpio_oe[8];
		eo[7:0] = m[17] ? mem_data_hi_out : mem_gpio_out[7:0];
		ee[7:0] = m[17] ? {8{mem_data_hi_oe}} : mem_gpio_oe[7:0];
		cmp({ext_mem_addr_pin_out, ext_mem_bank_addr_pin_out, ext_mem_data_pin_out}, eo);
		cmp({ext_mem_addr_pin_oe, ext_mem_bank_addr_pin_oe, ext_mem_data_pin_oe}, ee);
		cmp({mem_gpio_in, mem_data_hi_in}, {bin[23:13], bin[10:0], bin[7:0]});
		cmp(mem_if_pin_select_reg, m);
		cmp({vin_pin_out & vin_pin_oe, vin_pin_oe}, es[1][1:0] == 0 ? 32'h0 : es[1][1:0] == 1 ?
			{vin_spi_out & vin_spi_oe, vin_spi_oe} : {vin_gpio_out & vin_gpio_oe, vin_gpio_oe});
		// Back end and PWM lanes always drive; only the GPIO lane has its own enable
		cmp({vout_pin_out, vout_pin_oe}, es[2][1:0] == 0 ? {vout_out, 16'hFFFF} :
			es[2][1:0] == 1 ? {vout_pwm_out, 16'hFFFF} : {vout_gpio_out, vout_gpio_oe});
		cmp({gio_pin_out, gio_pin_oe}, {(gio_gpio_out & es[3][15:0]) | (gio_periph_out &
			~es[3][15:0]), (gio_gpio_oe & es[3][15:0]) | (gio_periph_oe & ~es[3][15:0])});
		cmp({ser_pin_out, ser_pin_oe}, es[4][1:0] == 0 ? {ser_card_out, ser_card_oe} :
			es[4][1:0] == 1 ? {ser_gpio_out, ser_gpio_oe} : {ser_uart_out, ser_uart_oe});
		cmp({video_in_pin_select_reg, video_out_pin_select_reg, gio_pin_select_reg,
			serial_card_pin_select_reg, mem_half_rate}, {es[1][1:0], es[2][1:0], es[3][15:0],
			es[4][1:0], ~m[18]});
		cmp(mem_pin_strap_code, code);
	endtask : pins

	// Strobe one select write for a single cycle
	task automatic wr(input int g, input logic [31:0] v);
		@(posedge clock);
		we <= 5'h01 << g;
		wd <= v;
		@(posedge clock);
		we <= 0;
		es[g] = v;
		@(negedge clock);
		if (g == 0) cmp(mem_if_pin_select_reg, v);
	endtask : wr

	// Reset with a strap; a write on the capture edge has to be ignored
	task automatic rst(input int n, input logic [3:0] c, input logic drv);
		@(posedge clock);
		rstn <= 0;
		strap_driven <= drv;
		mem_pin_config_strap <= c;
		repeat (n) @(posedge clock);
		@(negedge clock);
		cmp(ext_mem_addr_pin_oe, 0);
		@(posedge clock);
		rstn <= 1;
		we <= 5'h1F;
		wd <= $random(seed);
		@(posedge clock);
		we <= 0;
		mem_pin_config_strap <= ~c;
		code = drv ? c : STRAP_DEFAULT;
		es[0] = sf(code);
		for (int i = 1; i < 5; i++) begin
			es[i] = 0;
		end
		repeat (4) begin
			@(negedge clock);
			pins();
		end
	endtask : rst

	task automatic results;
		$display("checks %0d, errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results

	// Straps first, then random selections, then a rate change and its reset
	initial begin
		rnd();
		rst(12, 4'h0, 0);
		for (int i = 0; i < 8; i++) begin
			c32 = 32'hDCA8_20F5 >> (28 - 4 * i);
			rst(2, c32[3:0], 1);
		end
		for (int i = 0; i < 60; i++) begin
			d = $random(seed);
			d[18] = 0;
			wr(i % 5, d);
			@(negedge clock);
			pins();
		end
		wr(0, 32'h0004_0000);
		@(negedge clock);
		pins();
		rst(2, 4'h2, 1);
		results();
	end
endmodule : tb_top
